// ### logic/pii_core.sv
// interrupt input interface: prioritise, save state, vector and return
//
// Overview of operation
// - A critical request wins over an external one and may preempt an external handler.
// - An external interrupt is taken only with its enable set and no critical request present.
// - Taking an external interrupt waits for the instruction end, then saves next pc and state.
// - After that save the external enable is cleared and fetch moves to prefix plus ext offset.
// - The return instruction restores pc and state from the standard pair.
// - Taking a critical interrupt, gated by its enable, saves next pc and state in the crit pair.
// - After that save all interrupts are disabled and fetch moves to prefix plus crit offset.
// - The critical return instruction restores pc and state from the critical pair.
// - The interval and decrementing timers raise external requests, a second watchdog expiry a critical one.
// - Both request pins are active high levels, taken as long as present and enabled, the external one only without a critical request.
// - Each request pin goes through its own synchroniser.
// - The interconnect interrupt output rises whenever any crossbar device signals.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module pii_core
  import pii_pkg::*;
#(
  parameter int WD_CYCLES = WD_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DW-1:0] hrdata,
  input wire logic external_irq_in,
  input wire logic critical_irq_in,
  input wire logic [NXBAR-1:0] crossbarIrq,
  output logic interconnect_irq_out,
  input wire logic instrDone,
  input wire logic [DW-1:0] nextPc,
  input wire logic rfiExec,
  input wire logic rfciExec,
  output logic redirect,
  output logic [DW-1:0] redirectPc,
  output logic [DW-1:0] machine_state_word
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [DW-1:0] savePc_r;
  logic [DW-1:0] saveState_r;
  logic [DW-1:0] critSavePc_r;
  logic [DW-1:0] critSaveState_r;
  logic [DW-1:0] vectorPrefix_r;
  logic [DW-1:0] extOffset_r;
  logic [DW-1:0] critOffset_r;
  logic [TC_W-1:0] timerCtrl_r;
  logic [AW-1:0] addr_r;
  logic wrPend_r;
  logic rdPend_r;
  logic [DW-1:0] rdMux;
  logic [DW-1:0] statusWord;
  logic [NIRQ-1:0] pinLevel;
  logic [TC_W-1:0] clearFlags;
  logic [DW-1:0] decCount;
  logic fitFlag;
  logic decFlag;
  logic wdFirst;
  logic wdSecond;
  logic extReq;
  logic critReq;
  logic boundary;
  logic extTake;
  logic critTake;
  logic [DW-1:0] extVector;
  logic [DW-1:0] critVector;
  logic addrPhase;
  logic wrHit;

  // ----------------------------------------------------------------
  // request sources
  // ----------------------------------------------------------------
  pii_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pinIn({critical_irq_in, external_irq_in}),
    .levelOut(pinLevel)
  );

  pii_timers #(.WD_CYCLES(WD_CYCLES)) u_timers (
    .mclk(mclk),
    .rst(rst),
    .timerEnable(timerCtrl_r),
    .decLoad(wrHit && addr_r == ADDR_DEC),
    .decLoadValue(hwdata),
    .clearFlags(clearFlags),
    .fitFlag(fitFlag),
    .decFlag(decFlag),
    .wdFirst(wdFirst),
    .wdSecond(wdSecond),
    .decCount(decCount)
  );

  // levels, not edges: a held request keeps asking until cleared at source
  assign extReq = pinLevel[IRQ_EXT] || fitFlag || decFlag;
  assign critReq = pinLevel[IRQ_CRIT] || wdSecond;

  // ----------------------------------------------------------------
  // take decision
  // ----------------------------------------------------------------
  // a return in the same cycle wins; the level is still there next boundary
  assign boundary = instrDone && !rfiExec && !rfciExec;
  assign critTake = boundary && critReq && machine_state_word[MSW_CE];
  assign extTake = boundary && extReq && machine_state_word[MSW_EE] && !critReq;
  assign extVector = (vectorPrefix_r & VP_MASK) | (extOffset_r & OFF_MASK);
  assign critVector = (vectorPrefix_r & VP_MASK) | (critOffset_r & OFF_MASK);

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero wait, reads one wait state
  // ----------------------------------------------------------------
  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wrHit = wrPend_r;
  assign hreadyout = !rdPend_r;
  assign hresp = HRESP_OKAY;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r <= ADDR_MSW;
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
    end else begin
      if (addrPhase) addr_r <= haddr;
      wrPend_r <= addrPhase && hwrite;
      rdPend_r <= addrPhase && !hwrite;
    end
  end

  always_comb begin
    statusWord = ZERO_WORD;
    statusWord[ST_EXT_PEND] = extReq;
    statusWord[ST_CRIT_PEND] = critReq;
    statusWord[ST_FIT] = fitFlag;
    statusWord[ST_DEC] = decFlag;
    statusWord[ST_WD_FIRST] = wdFirst;
    statusWord[ST_WD_SECOND] = wdSecond;
    statusWord[ST_EXT_PIN] = pinLevel[IRQ_EXT];
    statusWord[ST_CRIT_PIN] = pinLevel[IRQ_CRIT];
  end

  always_comb begin
    case (addr_r)
      ADDR_MSW: rdMux = machine_state_word;
      ADDR_SAVE_PC: rdMux = savePc_r;
      ADDR_SAVE_ST: rdMux = saveState_r;
      ADDR_CSAVE_PC: rdMux = critSavePc_r;
      ADDR_CSAVE_ST: rdMux = critSaveState_r;
      ADDR_VPREFIX: rdMux = vectorPrefix_r;
      ADDR_EXT_OFF: rdMux = extOffset_r;
      ADDR_CRIT_OFF: rdMux = critOffset_r;
      ADDR_TCTRL: rdMux = {{(DW-TC_W){1'b0}}, timerCtrl_r};
      ADDR_DEC: rdMux = decCount;
      ADDR_STATUS: rdMux = statusWord;
      ADDR_REDIR: rdMux = redirectPc;
      default: rdMux = ZERO_WORD;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) hrdata <= ZERO_WORD;
    else if (rdPend_r) hrdata <= rdMux;
  end

  // write one to clear; the timer flags let a fresh event win
  always_comb begin
    clearFlags = '0;
    if (wrHit && addr_r == ADDR_STATUS) begin
      clearFlags[CLR_FIT] = hwdata[ST_FIT];
      clearFlags[CLR_DEC] = hwdata[ST_DEC];
      clearFlags[CLR_WD] = hwdata[ST_WD_FIRST] || hwdata[ST_WD_SECOND];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vectorPrefix_r <= ZERO_WORD;
      extOffset_r <= ZERO_WORD;
      critOffset_r <= ZERO_WORD;
      timerCtrl_r <= '0;
    end else if (wrHit) begin
      if (addr_r == ADDR_VPREFIX) vectorPrefix_r <= hwdata & VP_MASK;
      if (addr_r == ADDR_EXT_OFF) extOffset_r <= hwdata & OFF_MASK;
      if (addr_r == ADDR_CRIT_OFF) critOffset_r <= hwdata & OFF_MASK;
      if (addr_r == ADDR_TCTRL) timerCtrl_r <= hwdata[TC_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // machine state, hardware events beat a software write
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      machine_state_word <= ZERO_WORD;
    end else if (critTake) begin
      machine_state_word[MSW_EE] <= 1'b0;
      machine_state_word[MSW_CE] <= 1'b0;
    end else if (extTake) begin
      machine_state_word[MSW_EE] <= 1'b0;
    end else if (rfciExec) begin
      machine_state_word <= critSaveState_r;
    end else if (rfiExec) begin
      machine_state_word <= saveState_r;
    end else if (wrHit && addr_r == ADDR_MSW) begin
      machine_state_word <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // save pairs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      savePc_r <= ZERO_WORD;
      saveState_r <= ZERO_WORD;
    end else if (extTake) begin
      savePc_r <= nextPc;
      saveState_r <= machine_state_word;
    end else if (wrHit) begin
      if (addr_r == ADDR_SAVE_PC) savePc_r <= hwdata;
      if (addr_r == ADDR_SAVE_ST) saveState_r <= hwdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      critSavePc_r <= ZERO_WORD;
      critSaveState_r <= ZERO_WORD;
    end else if (critTake) begin
      critSavePc_r <= nextPc;
      critSaveState_r <= machine_state_word;
    end else if (wrHit) begin
      if (addr_r == ADDR_CSAVE_PC) critSavePc_r <= hwdata;
      if (addr_r == ADDR_CSAVE_ST) critSaveState_r <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // fetch redirect
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      redirect <= 1'b0;
      redirectPc <= ZERO_WORD;
    end else begin
      redirect <= critTake || extTake || rfciExec || rfiExec;
      if (critTake) redirectPc <= critVector;
      else if (extTake) redirectPc <= extVector;
      else if (rfciExec) redirectPc <= critSavePc_r;
      else if (rfiExec) redirectPc <= savePc_r;
    end
  end

  // crossbar devices share the same clock, so no synchroniser here
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) interconnect_irq_out <= 1'b0;
    else interconnect_irq_out <= |crossbarIrq;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence critEntry;
    critTake ##1 (redirect && redirectPc == $past(critVector));
  endsequence

  sequence extEntry;
    extTake ##1 (redirect && redirectPc == $past(extVector));
  endsequence

  a_crit_wins: assert property (@(posedge mclk) disable iff (rst)
    boundary && critReq && extReq && machine_state_word[MSW_CE] |-> critEntry)
    else $error("critical request did not win over external");

  a_ext_gated: assert property (@(posedge mclk) disable iff (rst)
    extTake |-> machine_state_word[MSW_EE] && !critReq && extReq)
    else $error("external taken while gated");

  a_ext_save: assert property (@(posedge mclk) disable iff (rst)
    extTake |=> savePc_r == $past(nextPc) && saveState_r == $past(machine_state_word))
    else $error("external save pair wrong");

  a_ext_vector: assert property (@(posedge mclk) disable iff (rst)
    extTake |-> extEntry ##0 !machine_state_word[MSW_EE])
    else $error("external entry did not vector or clear enable");

  a_rfi_restore: assert property (@(posedge mclk) disable iff (rst)
    rfiExec && !rfciExec |=> redirect && redirectPc == $past(savePc_r)
      && machine_state_word == $past(saveState_r))
    else $error("return did not restore standard pair");

  a_crit_save: assert property (@(posedge mclk) disable iff (rst)
    critTake |=> critSavePc_r == $past(nextPc)
      && critSaveState_r == $past(machine_state_word))
    else $error("critical save pair wrong");

  a_crit_disable: assert property (@(posedge mclk) disable iff (rst)
    critTake |-> critEntry ##0 !machine_state_word[MSW_EE] && !machine_state_word[MSW_CE])
    else $error("critical entry left interrupts enabled");

  a_rfci_restore: assert property (@(posedge mclk) disable iff (rst)
    rfciExec |=> redirect && redirectPc == $past(critSavePc_r)
      && machine_state_word == $past(critSaveState_r))
    else $error("critical return did not restore critical pair");

  a_level_taken: assert property (@(posedge mclk) disable iff (rst)
    boundary && pinLevel[IRQ_EXT] && machine_state_word[MSW_EE] |-> extTake || critReq)
    else $error("enabled external level not taken");

  a_icon_out: assert property (@(posedge mclk) disable iff (rst)
    ##1 interconnect_irq_out == $past(|crossbarIrq))
    else $error("interconnect output does not follow crossbar");

  a_pend_held: assert property (@(posedge mclk) disable iff (rst)
    extReq && !machine_state_word[MSW_EE] |-> !extTake)
    else $error("disabled external request was taken");

  a_crit_preempt: assert property (@(posedge mclk) disable iff (rst)
    boundary && critReq && machine_state_word[MSW_CE] |-> critEntry)
    else $error("enabled critical request did not preempt");

  a_crit_gated: assert property (@(posedge mclk) disable iff (rst)
    critTake |-> machine_state_word[MSW_CE] && critReq)
    else $error("critical taken while gated");

  a_crit_level: assert property (@(posedge mclk) disable iff (rst)
    boundary && pinLevel[IRQ_CRIT] && machine_state_word[MSW_CE] |-> critTake)
    else $error("enabled critical level not taken");

  a_ext_pair_hold: assert property (@(posedge mclk) disable iff (rst)
    !instrDone && !wrHit |=> $stable(savePc_r) && $stable(saveState_r))
    else $error("standard save pair moved off a boundary");

  a_crit_pair_hold: assert property (@(posedge mclk) disable iff (rst)
    !instrDone && !wrHit |=> $stable(critSavePc_r) && $stable(critSaveState_r))
    else $error("critical save pair moved off a boundary");
endmodule

// ### logic/pii_pkg.sv
// package with register map, field layout and timing constants of the interrupt input block
package pii_pkg;
  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int DW = 32;
  localparam int AW = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [AW-1:0] ADDR_MSW = 8'h00;
  localparam logic [AW-1:0] ADDR_SAVE_PC = 8'h04;
  localparam logic [AW-1:0] ADDR_SAVE_ST = 8'h08;
  localparam logic [AW-1:0] ADDR_CSAVE_PC = 8'h0c;
  localparam logic [AW-1:0] ADDR_CSAVE_ST = 8'h10;
  localparam logic [AW-1:0] ADDR_VPREFIX = 8'h14;
  localparam logic [AW-1:0] ADDR_EXT_OFF = 8'h18;
  localparam logic [AW-1:0] ADDR_CRIT_OFF = 8'h1c;
  localparam logic [AW-1:0] ADDR_TCTRL = 8'h20;
  localparam logic [AW-1:0] ADDR_DEC = 8'h24;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h28;
  localparam logic [AW-1:0] ADDR_REDIR = 8'h2c;
  localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int MSW_EE = 15;
  localparam int MSW_CE = 17;
  localparam logic [DW-1:0] VP_MASK = 32'hffff_0000;
  localparam logic [DW-1:0] OFF_MASK = 32'h0000_fff0;
  localparam int TC_FIT_EN = 0;
  localparam int TC_DEC_EN = 1;
  localparam int TC_WD_EN = 2;
  localparam int TC_W = 3;
  localparam int ST_EXT_PEND = 0;
  localparam int ST_CRIT_PEND = 1;
  localparam int ST_FIT = 2;
  localparam int ST_DEC = 3;
  localparam int ST_WD_FIRST = 4;
  localparam int ST_WD_SECOND = 5;
  localparam int ST_EXT_PIN = 6;
  localparam int ST_CRIT_PIN = 7;
  localparam int CLR_FIT = 0;
  localparam int CLR_DEC = 1;
  localparam int CLR_WD = 2;
  localparam int IRQ_EXT = 0;
  localparam int IRQ_CRIT = 1;
  localparam int NIRQ = 2;
  localparam int NXBAR = 4;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FIT_PERIOD_NS = 100000;
  localparam int WD_PERIOD_NS = 1000000;
  localparam int FIT_CYCLES = FIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WD_CYCLES_DEF = WD_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ### logic/pii_sync.sv
// three-stage synchroniser for the asynchronous interrupt request pins
`timescale 1ns/10ps
module pii_sync
  import pii_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [NIRQ-1:0] pinIn,
  output logic [NIRQ-1:0] levelOut
);
  // ----------------------------------------------------------------
  // per-pin stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NIRQ; i++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // stage one feeds stage two only; level moves once two and three agree
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          levelOut[i] <= 1'b0;
        end else begin
          s1_r <= pinIn[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) levelOut[i] <= s3_r;
        end
      end
      sequence pinSteady;
        pinIn[i] [*4];
      endsequence
      a_sync_rise: assert property (@(posedge mclk) disable iff (rst)
        pinSteady |=> levelOut[i])
        else $error("synchronised level did not follow a steady pin");
    end
  endgenerate
endmodule

// ### logic/pii_timers.sv
// on-core timer sources: fixed interval, decrementing and watchdog
`timescale 1ns/10ps
module pii_timers
  import pii_pkg::*;
#(
  parameter int WD_CYCLES = WD_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [TC_W-1:0] timerEnable,
  input wire logic decLoad,
  input wire logic [DW-1:0] decLoadValue,
  input wire logic [TC_W-1:0] clearFlags,
  output logic fitFlag,
  output logic decFlag,
  output logic wdFirst,
  output logic wdSecond,
  output logic [DW-1:0] decCount
);
  logic [DW-1:0] fitCnt_r;
  logic [DW-1:0] wdCnt_r;
  logic fitWrap;
  logic decHit;
  logic wdWrap;
  localparam logic [DW-1:0] FIT_LAST = DW'(FIT_CYCLES - 1);
  localparam logic [DW-1:0] WD_LAST = DW'(WD_CYCLES - 1);
  localparam logic [DW-1:0] ONE_WORD = 32'h0000_0001;

  assign fitWrap = timerEnable[TC_FIT_EN] && (fitCnt_r == FIT_LAST);
  assign decHit = timerEnable[TC_DEC_EN] && !decLoad && (decCount == ONE_WORD);
  assign wdWrap = timerEnable[TC_WD_EN] && (wdCnt_r == WD_LAST);

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) fitCnt_r <= ZERO_WORD;
    else if (!timerEnable[TC_FIT_EN] || fitWrap) fitCnt_r <= ZERO_WORD;
    else fitCnt_r <= fitCnt_r + ONE_WORD;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) decCount <= ZERO_WORD;
    else if (decLoad) decCount <= decLoadValue;
    else if (timerEnable[TC_DEC_EN] && decCount != ZERO_WORD) decCount <= decCount - ONE_WORD;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) wdCnt_r <= ZERO_WORD;
    else if (!timerEnable[TC_WD_EN] || wdWrap) wdCnt_r <= ZERO_WORD;
    else wdCnt_r <= wdCnt_r + ONE_WORD;
  end

  // ----------------------------------------------------------------
  // sticky flags, a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fitFlag <= 1'b0;
      decFlag <= 1'b0;
    end else begin
      fitFlag <= fitWrap || (fitFlag && !clearFlags[CLR_FIT]);
      decFlag <= decHit || (decFlag && !clearFlags[CLR_DEC]);
    end
  end

  // first expiry only arms; the second one raises the critical source
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdFirst <= 1'b0;
      wdSecond <= 1'b0;
    end else begin
      wdFirst <= wdWrap || (wdFirst && !clearFlags[CLR_WD]);
      wdSecond <= (wdWrap && wdFirst) || (wdSecond && !clearFlags[CLR_WD]);
    end
  end

  a_wd_second: assert property (@(posedge mclk) disable iff (rst)
    wdWrap && !wdFirst |=> wdFirst && !$rose(wdSecond))
    else $error("first watchdog expiry raised the critical source");
endmodule

// ### verif/pii_core_tb.sv
// self-checking bench for the interrupt input block
`timescale 1ns/10ps
module pii_core_tb
  import pii_pkg::*;
;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, interconnect_irq_out;
  logic external_irq_in, critical_irq_in, instrDone, rfiExec, rfciExec, redirect;
  logic [AW-1:0] haddr;
  logic [1:0] htrans, raiseReq, clearReq;
  logic [DW-1:0] hwdata, hrdata, nextPc, redirectPc, machine_state_word, q;
  logic [NXBAR-1:0] crossbarIrq;
  int failures = 0, cmp_count = 0, cyc = 0;
  localparam logic [DW-1:0] EE = 32'h1 << MSW_EE, CE = 32'h1 << MSW_CE;
  localparam logic [DW-1:0] VEXT = 32'habcd0040, VCRIT = 32'habcd0100;
  pii_core #(.WD_CYCLES(20)) i_pii_core (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_irq_in(external_irq_in),
    .critical_irq_in(critical_irq_in), .crossbarIrq(crossbarIrq),
    .interconnect_irq_out(interconnect_irq_out), .instrDone(instrDone), .nextPc(nextPc),
    .rfiExec(rfiExec), .rfciExec(rfciExec), .redirect(redirect), .redirectPc(redirectPc),
    .machine_state_word(machine_state_word));
  pii_eic_model i_pii_eic_model (.mclk(mclk), .rst(rst), .raiseReq(raiseReq),
    .clearReq(clearReq), .external_irq_in(external_irq_in), .critical_irq_in(critical_irq_in));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic rdc(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
    bus(1'b0, a, ZERO_WORD);
    chk(nm, q, e);
  endtask
  // one core event, then redirect and its pc judged in the cycle after
  task automatic core(input logic [DW-1:0] pc, input logic r, input logic rc,
      input logic expRed, input logic [DW-1:0] expPc);
    instrDone <= ~(r | rc); nextPc <= pc; rfiExec <= r; rfciExec <= rc;
    @(posedge mclk);
    instrDone <= 1'b0; rfiExec <= 1'b0; rfciExec <= 1'b0;
    @(posedge mclk);
    chk("redirect", {31'h0, redirect}, {31'h0, expRed});
    if (expRed) begin
      chk("redirectPc", redirectPc, expPc);
    end
  endtask
  // pins cross four flops, so give them six edges
  task automatic pins(input logic [1:0] up, input logic [1:0] dn);
    raiseReq <= up; clearReq <= dn;
    @(posedge mclk);
    raiseReq <= 2'h0; clearReq <= 2'h0;
    repeat (6) @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 6000) begin
      failures++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ext;
    bus(1'b1, ADDR_VPREFIX, 32'habcd1234);
    bus(1'b1, ADDR_EXT_OFF, 32'h0000_0047);
    bus(1'b1, ADDR_CRIT_OFF, 32'h0000_0100);
    rdc("unmapped", 8'hf0, ZERO_WORD);
    bus(1'b1, ADDR_MSW, EE);
    pins(2'h1, 2'h0);
    core(32'h1000, 1'b0, 1'b0, 1'b1, VEXT);
    rdc("save_pc", ADDR_SAVE_PC, 32'h1000);
    rdc("save_state", ADDR_SAVE_ST, EE);
    chk("ee cleared", machine_state_word & EE, ZERO_WORD);
    pins(2'h0, 2'h1);
    core(32'h0, 1'b1, 1'b0, 1'b1, 32'h1000);
    chk("word back", machine_state_word, EE);
    $display("external take and return done");
  endtask
  task automatic t_crit;
    bus(1'b1, ADDR_MSW, EE);
    pins(2'h3, 2'h0);
    core(32'h2000, 1'b0, 1'b0, 1'b0, ZERO_WORD);
    bus(1'b1, ADDR_MSW, EE | CE);
    core(32'h2004, 1'b0, 1'b0, 1'b1, VCRIT);
    rdc("csave_pc", ADDR_CSAVE_PC, 32'h2004);
    rdc("csave_st", ADDR_CSAVE_ST, EE | CE);
    chk("all off", machine_state_word & (EE | CE), ZERO_WORD);
    pins(2'h0, 2'h2);
    core(32'h0, 1'b0, 1'b1, 1'b1, 32'h2004);
    chk("word crit back", machine_state_word, EE | CE);
    core(32'h2008, 1'b0, 1'b0, 1'b1, VEXT);
    pins(2'h0, 2'h1);
    $display("critical priority done");
  endtask
  task automatic t_pend;
    bus(1'b1, ADDR_MSW, ZERO_WORD);
    pins(2'h1, 2'h0);
    core(32'h3000, 1'b0, 1'b0, 1'b0, ZERO_WORD);
    bus(1'b0, ADDR_STATUS, ZERO_WORD);
    chk("ext pending", (q >> ST_EXT_PEND) & 32'h1, 32'h1);
    bus(1'b1, ADDR_MSW, EE);
    core(32'h3004, 1'b0, 1'b0, 1'b1, VEXT);
    pins(2'h0, 2'h1);
    $display("pending done");
  endtask
  task automatic t_timers;
    bus(1'b1, ADDR_DEC, 32'h3);
    bus(1'b1, ADDR_TCTRL, 32'h1 << TC_DEC_EN);
    repeat (8) @(posedge mclk);
    bus(1'b0, ADDR_STATUS, ZERO_WORD);
    chk("dec flag", (q >> ST_DEC) & 32'h1, 32'h1);
    bus(1'b1, ADDR_MSW, EE);
    core(32'h4000, 1'b0, 1'b0, 1'b1, VEXT);
    bus(1'b1, ADDR_MSW, CE);
    bus(1'b1, ADDR_TCTRL, 32'h1 << TC_WD_EN);
    repeat (50) @(posedge mclk);
    bus(1'b0, ADDR_STATUS, ZERO_WORD);
    chk("wd second", (q >> ST_WD_SECOND) & 32'h1, 32'h1);
    core(32'h4004, 1'b0, 1'b0, 1'b1, VCRIT);
    bus(1'b1, ADDR_TCTRL, ZERO_WORD);
    rdc("last redirect", ADDR_REDIR, VCRIT);
    bus(1'b1, ADDR_STATUS, 32'h3c);
    rdc("flags cleared", ADDR_STATUS, ZERO_WORD);
    bus(1'b1, ADDR_TCTRL, 32'h1 << TC_FIT_EN);
    repeat (FIT_CYCLES) @(posedge mclk);
    rdc("fit flag", ADDR_STATUS, (32'h1 << ST_FIT) | (32'h1 << ST_EXT_PEND));
    bus(1'b1, ADDR_TCTRL, ZERO_WORD);
    $display("timers done");
  endtask
  task automatic t_xbar;
    for (int i = 0; i < NXBAR; i++) begin
      crossbarIrq <= NXBAR'(1 << i);
      repeat (2) @(posedge mclk);
      chk("xbar on", {31'h0, interconnect_irq_out}, 32'h1);
      crossbarIrq <= '0;
      repeat (2) @(posedge mclk);
      chk("xbar off", {31'h0, interconnect_irq_out}, 32'h0);
    end
    $display("interconnect done");
  endtask
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hwdata = '0;
    crossbarIrq = '0; instrDone = 1'b0; nextPc = '0; rfiExec = 1'b0; rfciExec = 1'b0;
    raiseReq = 2'h0; clearReq = 2'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_ext();
    t_crit();
    t_pend();
    t_timers();
    t_xbar();
    test_done();
  end
endmodule

// ### verif/pii_eic_model.sv
// behavioural external interrupt controller driving the two request pins
`timescale 1ns/10ps
module pii_eic_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] raiseReq,
  input wire logic [1:0] clearReq,
  output logic external_irq_in,
  output logic critical_irq_in
);
  logic [1:0] req_r;
  // ----------------------------------------------------------------
  // request latches
  // ----------------------------------------------------------------
  // held until software clears; the clear lands before the write ends
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_r <= 2'h0;
    end else begin
      req_r <= (req_r | raiseReq) & ~clearReq;
    end
  end
  assign external_irq_in = req_r[0];
  assign critical_irq_in = req_r[1];
endmodule
